// ### include/homing_latch_defines.vh
// register map, field codes and timing constants for homing and capture
`ifndef HOMING_LATCH_DEFINES_VH
`define HOMING_LATCH_DEFINES_VH
// word addresses (byte address / 4) on the avalon slave
`define REG_CMD 4'h0
`define REG_CONFIG 4'h1
`define REG_SPEED 4'h2
`define REG_STATUS 4'h3
`define REG_STOP 4'h4
`define REG_ARM 4'h5
`define REG_CAPT_BASE 4'h8
// command codes written to the command register bits 2:0
`define CMD_NONE 3'h0
`define CMD_FIND_EDGE 3'h1
`define CMD_FULL_HOME 3'h2
`define CMD_FIND_INDEX 3'h3
`define CMD_ABORT 3'h4
// stop reasons
`define STOP_RUNNING 8'h00
`define STOP_EDGE_DONE 8'h01
`define STOP_HOME_DONE 8'h02
`define STOP_INDEX_DONE 8'h03
`define STOP_ABORTED 8'h04
// servo periods and capture limit in microseconds, clock rate in MHz, unmapped read data
`define FAST_PERIOD_SMALL_US 125
`define FAST_PERIOD_LARGE_US 250
`define NORMAL_PERIOD_US 1000
`define CAPTURE_MAX_US 25
`define CLK_MHZ 50
`define UNMAPPED_DATA 32'hDEADBEEF
`endif

// ### rtl/homing_and_position_latch.v
// per-axis homing sequencer, position capture and fast mode controls
// Summary of operation
// - find edge slews until home changes, stops
// - full home initial direction: home low forward, high reverse; find edge direction from command bit
// - configurable home input polarity
// - full home decelerates on home change
// - then creeps back until home toggles
// - then moves forward until index pulse
// - position zeroed at captured index position
// - separate find index operation per axis
// - home level, stop reason, status readable
// - capture position within 25 us of low
// - inputs one to four trigger axes one to four
// - arm selects main or auxiliary encoder
// - pending flag reads one until triggered
// - captured value held until rearmed
// - one capture per arming, rearm required
// - fast period 125 us small, 250 us large
// - servo period set by time-base command
// - fast mode disables listed functions
`timescale 1ns/1ns
`include "homing_latch_defines.vh"
module homing_and_position_latch #(
    parameter AXES = 4,
    parameter POS_W = 32,
    parameter SMALL_VARIANT = 0,
    parameter TICK_DIV_NORMAL = `NORMAL_PERIOD_US * `CLK_MHZ
)(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire [AXES-1:0] home_input_in,
    input wire [AXES-1:0] index_input_in,
    input wire [AXES-1:0] axis_capture_input_in,
    input wire [AXES*POS_W-1:0] main_position_in,
    input wire [AXES*POS_W-1:0] aux_position_in,
    output reg [AXES-1:0] motion_enable_out,
    output reg [AXES-1:0] motion_reverse_out,
    output reg [AXES-1:0] motion_slow_out,
    output reg [AXES-1:0] motion_stop_out,
    output reg [AXES-1:0] position_zero_out,
    output reg [AXES*POS_W-1:0] zero_position_out,
    output reg servo_tick_out,
    output reg [8:0] fast_disable_out
);
    // homing states, one-hot
    localparam ST_IDLE = 6'b000001;
    localparam ST_SLEW = 6'b000010;
    localparam ST_DECEL = 6'b000100;
    localparam ST_CREEP = 6'b001000;
    localparam ST_SEEK_INDEX = 6'b010000;
    localparam ST_DONE = 6'b100000;
    // clocks per servo tick in fast mode
    localparam FAST_DIV = (SMALL_VARIANT ? `FAST_PERIOD_SMALL_US
        : `FAST_PERIOD_LARGE_US) * `CLK_MHZ;
    // clocks within which a capture must complete
    localparam CAPT_CYC = `CAPTURE_MAX_US * `CLK_MHZ;

    // extract one axis slice from a packed position bus
    function [POS_W-1:0] slice;
        input [AXES*POS_W-1:0] bus;
        input integer idx;
        begin
            slice = bus[idx*POS_W +: POS_W];
        end
    endfunction

    // pin synchronisers, two flops each
    reg [AXES-1:0] home_s1_q, home_s2_q, home_prev_q;
    reg [AXES-1:0] idx_s1_q, idx_s2_q, idx_prev_q;
    reg [AXES-1:0] cap_s1_q, cap_s2_q, cap_prev_q;
    // configuration and control registers
    reg [AXES-1:0] polarity_q; // home polarity invert per axis
    reg [15:0] period_div_q; // programmed servo period in clocks
    reg fast_mode_q; // fast update mode enable
    reg [15:0] tick_cnt_q; // servo tick divider
    reg [AXES*6-1:0] state_q; // per-axis homing state
    reg [AXES*3-1:0] op_q; // per-axis active operation
    reg [AXES*8-1:0] stop_q; // per-axis stop reason
    reg [AXES-1:0] pending_q; // capture armed, not triggered
    reg [AXES-1:0] use_aux_q; // capture source select
    reg [AXES*POS_W-1:0] capt_q; // captured positions
    reg [AXES*POS_W-1:0] ipos_q; // index capture for zeroing
    reg rd_done_q; // one-cycle wait state marker
    wire [AXES-1:0] home_lvl = home_s2_q ^ polarity_q;
    wire [AXES-1:0] home_chg = home_s2_q ^ home_prev_q;
    wire [AXES-1:0] idx_rise = idx_s2_q & ~idx_prev_q;
    wire [AXES-1:0] cap_fall = ~cap_s2_q & cap_prev_q;
    wire bus_req = avs_read_in | avs_write_in;
    wire bus_take = bus_req & rd_done_q;
    wire wr = avs_write_in & bus_take;
    integer i;

    // input synchronisers and edge history
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            home_s1_q <= {AXES{1'b0}};
            home_s2_q <= {AXES{1'b0}};
            home_prev_q <= {AXES{1'b0}};
            idx_s1_q <= {AXES{1'b0}};
            idx_s2_q <= {AXES{1'b0}};
            idx_prev_q <= {AXES{1'b0}};
            cap_s1_q <= {AXES{1'b1}};
            cap_s2_q <= {AXES{1'b1}};
            cap_prev_q <= {AXES{1'b1}};
        end
        else
        begin
            home_s1_q <= home_input_in;
            home_s2_q <= home_s1_q;
            home_prev_q <= home_s2_q;
            idx_s1_q <= index_input_in;
            idx_s2_q <= idx_s1_q;
            idx_prev_q <= idx_s2_q;
            cap_s1_q <= axis_capture_input_in;
            cap_s2_q <= cap_s1_q;
            cap_prev_q <= cap_s2_q;
        end
    end

    // servo tick generator, fast or programmed period
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            tick_cnt_q <= 16'h0000;
            servo_tick_out <= 1'b0;
        end
        else if (tick_cnt_q == 16'h0000)
        begin
            // reload from active period
            tick_cnt_q <= fast_mode_q ? FAST_DIV[15:0] - 16'h0001
                : period_div_q - 16'h0001;
            servo_tick_out <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q - 16'h0001;
            servo_tick_out <= 1'b0;
        end
    end

    // avalon slave: one wait state, then answer
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            rd_done_q <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            polarity_q <= {AXES{1'b0}};
            period_div_q <= TICK_DIV_NORMAL[15:0];
            fast_mode_q <= 1'b0;
            fast_disable_out <= 9'h000;
        end
        else
        begin
            // hold waitrequest high for one cycle of each request
            rd_done_q <= bus_req & ~rd_done_q;
            avs_waitrequest_out <= ~(bus_req & ~rd_done_q);
            fast_disable_out <= {9{fast_mode_q}};
            if (wr && avs_address_in == `REG_CONFIG)
            begin
                polarity_q <= avs_writedata_in[AXES-1:0];
                fast_mode_q <= avs_writedata_in[8];
            end
            if (wr && avs_address_in == `REG_SPEED)
                period_div_q <= avs_writedata_in[15:0];
            if (avs_read_in && bus_req && !rd_done_q)
            begin
                // read mux, data ready as waitrequest drops
                case (avs_address_in)
                `REG_CONFIG:
                    avs_readdata_out <= {23'h000000, fast_mode_q,
                        {(8-AXES){1'b0}}, polarity_q};
                `REG_SPEED:
                    avs_readdata_out <= {16'h0000, period_div_q};
                `REG_STATUS:
                    avs_readdata_out <= {16'h0000,
                        {(4-AXES){1'b0}}, pending_q,
                        {(4-AXES){1'b0}}, cap_s2_q,
                        {(4-AXES){1'b0}}, idx_s2_q,
                        {(4-AXES){1'b0}}, home_lvl};
                `REG_STOP:
                    avs_readdata_out <= stop_q[31:0];
                `REG_ARM:
                    avs_readdata_out <= {{(32-2*AXES){1'b0}},
                        use_aux_q, pending_q};
                `REG_CMD:
                    avs_readdata_out <= {{(32-3*AXES){1'b0}}, op_q};
                default:
                    if (avs_address_in >= `REG_CAPT_BASE &&
                        avs_address_in < `REG_CAPT_BASE + AXES)
                        avs_readdata_out <= slice(capt_q,
                            avs_address_in - `REG_CAPT_BASE);
                    else
                        avs_readdata_out <= `UNMAPPED_DATA;
                endcase
            end
        end
    end

    // capture logic per axis
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            pending_q <= {AXES{1'b0}};
            use_aux_q <= {AXES{1'b0}};
            capt_q <= {AXES*POS_W{1'b0}};
        end
        else
        begin
            for (i = 0; i < AXES; i = i + 1)
            begin
                if (pending_q[i] && cap_fall[i])
                begin
                    // capture in 3 clocks, well inside CAPT_CYC
                    capt_q[i*POS_W +: POS_W] <= use_aux_q[i]
                        ? slice(aux_position_in, i)
                        : slice(main_position_in, i);
                    pending_q[i] <= 1'b0;
                end
                else if (wr && avs_address_in == `REG_ARM &&
                    avs_writedata_in[i])
                begin
                    pending_q[i] <= 1'b1;
                    use_aux_q[i] <= avs_writedata_in[i+4];
                end
            end
        end
    end

    // homing sequencers per axis
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= {AXES{ST_IDLE}};
            op_q <= {AXES{`CMD_NONE}};
            stop_q <= {AXES{`STOP_RUNNING}};
            ipos_q <= {AXES*POS_W{1'b0}};
            motion_enable_out <= {AXES{1'b0}};
            motion_reverse_out <= {AXES{1'b0}};
            motion_slow_out <= {AXES{1'b0}};
            motion_stop_out <= {AXES{1'b0}};
            position_zero_out <= {AXES{1'b0}};
            zero_position_out <= {AXES*POS_W{1'b0}};
        end
        else
        begin
            position_zero_out <= {AXES{1'b0}};
            for (i = 0; i < AXES; i = i + 1)
            begin
                if (wr && avs_address_in == `REG_CMD &&
                    avs_writedata_in[2:0] == `CMD_ABORT &&
                    avs_writedata_in[8+i])
                begin
                    state_q[i*6 +: 6] <= ST_IDLE;
                    motion_enable_out[i] <= 1'b0;
                    stop_q[i*8 +: 8] <= `STOP_ABORTED;
                end
                else
                case (state_q[i*6 +: 6])
                ST_IDLE:
                    if (wr && avs_address_in == `REG_CMD &&
                        avs_writedata_in[8+i] &&
                        avs_writedata_in[2:0] != `CMD_NONE &&
                        avs_writedata_in[2:0] != `CMD_ABORT)
                    begin
                        op_q[i*3 +: 3] <= avs_writedata_in[2:0];
                        stop_q[i*8 +: 8] <= `STOP_RUNNING;
                        motion_enable_out[i] <= 1'b1;
                        motion_stop_out[i] <= 1'b0;
                        motion_slow_out[i] <= 1'b0;
                        if (avs_writedata_in[2:0] == `CMD_FULL_HOME)
                            motion_reverse_out[i] <= home_lvl[i];
                        else
                            motion_reverse_out[i] <= avs_writedata_in[12+i];
                        state_q[i*6 +: 6] <= (avs_writedata_in[2:0] ==
                            `CMD_FIND_INDEX) ? ST_SEEK_INDEX
                            : ST_SLEW;
                    end
                ST_SLEW:
                    if (home_chg[i])
                    begin
                        motion_stop_out[i] <= 1'b1;
                        state_q[i*6 +: 6] <= ST_DECEL;
                    end
                ST_DECEL:
                    if (servo_tick_out)
                    begin
                        // one servo tick to settle the stop request
                        motion_stop_out[i] <= 1'b0;
                        if (op_q[i*3 +: 3] == `CMD_FULL_HOME)
                        begin
                            motion_reverse_out[i] <= ~motion_reverse_out[i];
                            motion_slow_out[i] <= 1'b1;
                            state_q[i*6 +: 6] <= ST_CREEP;
                        end
                        else
                        begin
                            motion_enable_out[i] <= 1'b0;
                            stop_q[i*8 +: 8] <= `STOP_EDGE_DONE;
                            state_q[i*6 +: 6] <= ST_DONE;
                        end
                    end
                ST_CREEP:
                    if (home_chg[i])
                    begin
                        motion_reverse_out[i] <= 1'b0;
                        state_q[i*6 +: 6] <= ST_SEEK_INDEX;
                    end
                ST_SEEK_INDEX:
                    if (idx_rise[i])
                    begin
                        ipos_q[i*POS_W +: POS_W] <=
                            slice(main_position_in, i);
                        motion_enable_out[i] <= 1'b0;
                        motion_slow_out[i] <= 1'b0;
                        if (op_q[i*3 +: 3] == `CMD_FULL_HOME)
                        begin
                            // zero counter at the index position
                            position_zero_out[i] <= 1'b1;
                            zero_position_out[i*POS_W +: POS_W] <=
                                slice(main_position_in, i);
                            stop_q[i*8 +: 8] <= `STOP_HOME_DONE;
                        end
                        else
                            stop_q[i*8 +: 8] <= `STOP_INDEX_DONE;
                        state_q[i*6 +: 6] <= ST_DONE;
                    end
                ST_DONE:
                    state_q[i*6 +: 6] <= ST_IDLE;
                default:
                    state_q[i*6 +: 6] <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ### tb/encoder_switch_model.sv
// encoder, index and home switch model on the motion side
`timescale 1ns/1ns
module encoder_switch_model #(
    parameter HOME_AT = 200
)(
    input wire ref_clk_in,
    input wire [3:0] enable_in,
    input wire [3:0] reverse_in,
    input wire [3:0] slow_in,
    input wire [3:0] stop_in,
    output logic [3:0] home_out,
    output logic [3:0] index_out,
    output logic [127:0] main_pos_out,
    output logic [127:0] aux_pos_out
);
    logic [31:0] pos_q [0:3]; // per-axis count
    logic [1:0] div_q = 2'h0; // creep divider, one step in four
    integer j;
    integer k;
    initial
    begin
        for (j = 0; j < 4; j = j + 1)
            pos_q[j] = 32'h10 + 32'h100 * j;
    end
    // count moves; stop freezes at once like a high deceleration
    always @(posedge ref_clk_in)
    begin
        div_q <= div_q + 2'h1;
        for (j = 0; j < 4; j = j + 1)
            if (enable_in[j] && !stop_in[j] &&
                (!slow_in[j] || div_q == 2'h0))
                pos_q[j] <= reverse_in[j] ? pos_q[j] - 32'h1 :
                    pos_q[j] + 32'h1;
    end
    // switch above a point, index every 64 counts
    always_comb
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            home_out[k] = pos_q[k] >= HOME_AT;
            index_out[k] = pos_q[k][5:0] == 6'h00;
            main_pos_out[32*k +: 32] = pos_q[k];
            aux_pos_out[32*k +: 32] = pos_q[k] + 32'h10000;
        end
    end
endmodule

// ### tb/homing_latch_props.sv
// checker for bus handshake, pulses and fast mode outputs
`timescale 1ns/1ns
`include "homing_latch_defines.vh"
module homing_latch_props #(
    parameter AXES = 4,
    parameter POS_W = 32
)(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire [AXES-1:0] position_zero_out,
    input wire servo_tick_out,
    input wire [8:0] fast_disable_out
);
    // any bus request present
    wire req = avs_read_in | avs_write_in;
    // configuration write accepted in this cycle
    wire cfg_wr = avs_write_in & ~avs_waitrequest_out &
        (avs_address_in == `REG_CONFIG);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_wait_answer;
        $rose(req) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_wait_answer: assert property (p_wait_answer)
        else $error("waitrequest did not drop after request");
    property p_wait_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low longer than one cycle");
    property p_wait_idle;
        !req |=> avs_waitrequest_out;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("waitrequest low without request");
    property p_unmapped;
        avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h6
            |-> avs_readdata_out == `UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read gave wrong data");
    property p_fast_all;
        fast_disable_out == 9'h000 || fast_disable_out == 9'h1FF;
    endproperty
    a_fast_all: assert property (p_fast_all)
        else $error("fast mode disables only part of the list");
    property p_fast_cause;
        $changed(fast_disable_out) |-> $past(cfg_wr) || $past(cfg_wr, 2);
    endproperty
    a_fast_cause: assert property (p_fast_cause)
        else $error("fast mode changed without config write");
    property p_tick_pulse;
        servo_tick_out |=> !servo_tick_out;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("servo tick wider than one cycle");
    property p_zero_pulse;
        position_zero_out[0] |=> !position_zero_out[0];
    endproperty
    a_zero_pulse: assert property (p_zero_pulse)
        else $error("zero pulse wider than one cycle");
endmodule

// ### tb/tb_homing_and_position_latch.sv
// bench for homing sequences, position capture and bus access
`timescale 1ns/1ns
`include "homing_latch_defines.vh"
module tb_homing_and_position_latch;
    reg ref_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [3:0] adr = 4'h0; // bus request fields
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdat = 32'h0;
    reg [3:0] cap_pin = 4'hF; // capture pins idle high
    wire [31:0] rdat;
    wire wait_o;
    wire [3:0] home, index, en, rev, slow, stop, zero;
    wire [127:0] main_pos, aux_pos, zero_pos;
    wire tick;
    wire [8:0] fast_off;
    integer fails = 0;
    integer checks_done = 0;
    reg en_prev = 1'b0;
    reg first_rev = 1'b0; // direction at motion start
    reg creep_seen = 1'b0; // slow reverse seen
    reg [31:0] zpos = 32'h0; // zero point taken at index
    reg [31:0] got; // last read data
    integer i, n, k;
    always #10 ref_clk_in = ~ref_clk_in;
    homing_and_position_latch #(.TICK_DIV_NORMAL(50)) dut_u (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_o), .home_input_in(home),
        .index_input_in(index), .axis_capture_input_in(cap_pin),
        .main_position_in(main_pos), .aux_position_in(aux_pos),
        .motion_enable_out(en), .motion_reverse_out(rev),
        .motion_slow_out(slow), .motion_stop_out(stop),
        .position_zero_out(zero), .zero_position_out(zero_pos),
        .servo_tick_out(tick), .fast_disable_out(fast_off));
    encoder_switch_model model_u (
        .ref_clk_in(ref_clk_in), .enable_in(en), .reverse_in(rev),
        .slow_in(slow), .stop_in(stop), .home_out(home),
        .index_out(index), .main_pos_out(main_pos), .aux_pos_out(aux_pos));
    // watch axis 0 direction, creep and zero point
    always @(posedge ref_clk_in)
    begin
        en_prev <= en[0];
        if (en[0] && !en_prev)
            first_rev <= rev[0];
        if (en[0] && slow[0] && rev[0])
            creep_seen <= 1'b1;
        if (zero[0])
            zpos <= zero_pos[31:0];
    end
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] seen);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    // one avalon cycle, held until waitrequest sampled low
    task bus(input logic w, input [3:0] a, input [31:0] d);
    begin
        @(posedge ref_clk_in);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        @(posedge ref_clk_in);
        while (wait_o !== 1'b0 && n < 100)
        begin
            n = n + 1;
            @(posedge ref_clk_in);
        end
        got = rdat;
        if (n == 100)
            fails = fails + 1;
        wr <= 1'b0;
        rd <= 1'b0;
    end
    endtask
    task rd_chk(input string name, input [3:0] a, input [31:0] exp);
    begin
        bus(1'b0, a, 32'h0);
        chk(name, exp, got);
    end
    endtask
    // poll axis 0 stop reason until motion ends
    task wait_stop;
    begin
        got = 32'h0;
        for (i = 0; i < 400 && got[7:0] === `STOP_RUNNING; i = i + 1)
            bus(1'b0, `REG_STOP, 32'h0);
    end
    endtask
    // main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd_chk("stop reset", `REG_STOP, 32'h0);
        rd_chk("unmapped", 4'h6, `UNMAPPED_DATA);
        bus(1'b1, 4'h7, 32'h0);
        rd_chk("unmapped write", 4'h7, `UNMAPPED_DATA);
        bus(1'b1, `REG_SPEED, 32'h32);
        rd_chk("period", `REG_SPEED, 32'h32);
        wait (tick === 1'b1);
        @(negedge ref_clk_in);
        n = 0;
        do
        begin
            @(negedge ref_clk_in);
            n = n + 1;
        end while (tick !== 1'b1 && n < 200);
        chk("tick spacing", 32'd50, n);
        rd_chk("status", `REG_STATUS, 32'h0F0E);
        bus(1'b1, `REG_CONFIG, 32'h1);
        rd_chk("inverted home", `REG_STATUS, 32'h0F0F);
        // toggle fast mode right after a tick, so no reload sees it
        wait (tick === 1'b1);
        bus(1'b1, `REG_CONFIG, 32'h100);
        // disable word follows the mode flag one clock later
        repeat (2) @(posedge ref_clk_in);
        chk("fast off", 32'h1FF, fast_off);
        bus(1'b1, `REG_CONFIG, 32'h0);
        repeat (2) @(posedge ref_clk_in);
        chk("fast on", 32'h0, fast_off);
        bus(1'b1, `REG_ARM, 32'h2F);
        rd_chk("armed", `REG_ARM, 32'h2F);
        for (k = 0; k < 4; k = k + 1)
        begin
            @(posedge ref_clk_in);
            cap_pin[k] <= 1'b0;
            repeat (10) @(posedge ref_clk_in);
            rd_chk("pending", `REG_ARM,
                ((32'hF << (k + 1)) & 32'hF) | 32'h20);
            rd_chk("captured", `REG_CAPT_BASE + k[3:0], 32'h10 +
                32'h100 * k + (k == 1 ? 32'h10000 : 32'h0));
        end
        bus(1'b1, `REG_CMD, 32'h0102);
        wait_stop;
        chk("home stop", `STOP_HOME_DONE, got & 32'hFF);
        chk("home dir", 32'h0, first_rev);
        chk("creep back", 32'h1, creep_seen);
        chk("zero at index", 32'h1, (zpos - 32'd256) < 32'd8);
        bus(1'b1, `REG_CMD, 32'h1101);
        wait_stop;
        chk("edge stop", `STOP_EDGE_DONE, got & 32'hFF);
        chk("edge dir", 32'h1, first_rev);
        bus(1'b1, `REG_CMD, 32'h0103);
        wait_stop;
        chk("index stop", `STOP_INDEX_DONE, got & 32'hFF);
        // home already high: edge search runs until aborted
        bus(1'b1, `REG_CMD, 32'h0101);
        bus(1'b1, `REG_CMD, 32'h0104);
        rd_chk("abort stop", `REG_STOP, 32'h04);
        chk("abort halt", 32'h0, en[0]);
        cap_pin <= 4'hF;
        repeat (10) @(posedge ref_clk_in);
        cap_pin[0] <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        rd_chk("held capture", `REG_CAPT_BASE, 32'h10);
        rd_chk("no rearm", `REG_ARM, 32'h20);
        // fast period last: its long reload would stall the homing tests
        bus(1'b1, `REG_CONFIG, 32'h100);
        // any tick seen from here on was reloaded in fast mode
        repeat (2) @(posedge ref_clk_in);
        wait (tick === 1'b1);
        @(negedge ref_clk_in);
        n = 0;
        do
        begin
            @(negedge ref_clk_in);
            n = n + 1;
        end while (tick !== 1'b1 && n < 20000);
        chk("fast period", `FAST_PERIOD_LARGE_US * `CLK_MHZ, n);
        report_and_stop;
    end
    // watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge ref_clk_in);
        fails = fails + 1;
        report_and_stop;
    end
endmodule
bind homing_and_position_latch homing_latch_props #(
    .AXES(AXES), .POS_W(POS_W)) props_u (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .position_zero_out(position_zero_out),
    .servo_tick_out(servo_tick_out), .fast_disable_out(fast_disable_out));
